// ==== verilog/ebr_pkg.sv ====
// constants, modes and carriers shared by the embedded memory block
`default_nettype none
package ebr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DEPTH = 256;
	localparam int SHIFT_W = 8;
	localparam int TAP_SPACING = 16;
	localparam int TAP_COUNT = 4;
	localparam int SHIFT_LEN = SHIFT_W * 0 + TAP_SPACING * TAP_COUNT;
	localparam int SHIFT_IDX_W = 6;
	localparam int QCNT_W = 9;
	localparam int OPND_W = 4;
	localparam int PROD_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam int BUF_CNT_W = 2;
	localparam int IMAGE_TAG_W = DATA_W - PROD_W;
	// arbitrary filler for the upper bits of the preload image
	localparam logic [IMAGE_TAG_W-1:0] IMAGE_TAG = 24'h5A0000;
	localparam logic [QCNT_W-1:0] QUEUE_DEPTH = 9'h100;
	localparam logic [BUF_CNT_W-1:0] BUF_FULL = 2'h2;

	typedef logic [DATA_W-1:0] word_t;
	typedef logic [SHIFT_W-1:0] shift_word_t;

	typedef enum logic [3:0] {
		MODE_SINGLE_PORT_RAM = 4'h0,
		MODE_SIMPLE_DUAL_RAM = 4'h1,
		MODE_TRUE_DUAL_RAM = 4'h2,
		MODE_SINGLE_PORT_ROM = 4'h3,
		MODE_DUAL_PORT_ROM = 4'h4,
		MODE_SHIFT_REGISTER = 4'h5,
		MODE_SINGLE_CLOCK_QUEUE = 4'h6,
		MODE_DUAL_CLOCK_QUEUE = 4'h7,
		MODE_MULTIPLIER = 4'h8
	} mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		word_t wdata;
		logic [LANES-1:0] byte_en;
		logic wr_en;
		logic rd_en;
	} port_req_t;

	localparam port_req_t REQ_IDLE = '0;

	// build-time preload: low byte is the product of the two address nibbles
	function automatic word_t rom_image(input logic [ADDR_W-1:0] idx);
		logic [PROD_W-1:0] prod;
		prod = PROD_W'(idx[ADDR_W-1:OPND_W] * idx[OPND_W-1:0]);
		return {IMAGE_TAG, prod};
	endfunction
endpackage
`default_nettype wire

// ==== verilog/embedded_ram_block.sv ====
// configurable synchronous memory block: RAM, ROM, shift register, queue, multiplier
`default_nettype none
// Functional notes
// - single-port RAM uses port A only; read and write may be issued together.
// - read strobe during write shows new or old data, chosen at build time.
// - write with read strobe low keeps the last read output.
// - simple dual-port: write on port A, read on port B, same cycle.
// - true dual-port: each port reads or writes on its own.
// - true dual-port ports may run at different rates.
// - single-port ROM: one read-only address port, no write path.
// - ROM address inputs are registered before the array is accessed.
// - ROM read output selectable as registered or unregistered.
// - ROM reads share the single-port RAM read timing and output behaviour.
// - dual-port ROM adds a second independent read port with own output.
// - ROM contents are preloaded from a build-time image.
// - shift register holds width times spacing times taps, outputs every tap.
// - last tap feeds the next block's input for longer chains.
// - single-clock and dual-clock queue modes are provided; the dual mode runs on the one clock, with ena_b setting its read rate.
// - operands form the read address, stored products return as data.
// - every memory input passes an input register; q_out_ready drives the queue pop and drain directly.
// - writes gated by strobe and active-high lane mask; a zero mask writes no lane.
module embedded_ram_block
	import ebr_pkg::*;
#(
	parameter bit RDW_NEW_DATA = 1'b1,
	parameter bit OUT_REGISTERED = 1'b0
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire mode_t mode,
	input wire logic ena_a,
	input wire logic ena_b,
	input wire port_req_t port_a,
	input wire port_req_t port_b,
	output logic [DATA_W-1:0] rd_data_a,
	output logic [DATA_W-1:0] rd_data_b,
	input wire logic [SHIFT_W-1:0] shift_in,
	input wire logic shift_en,
	output logic [TAP_COUNT-1:0][SHIFT_W-1:0] taps,
	output logic [SHIFT_W-1:0] shift_out,
	input wire logic q_push,
	input wire logic [DATA_W-1:0] q_push_data,
	output logic q_in_ready,
	output logic q_out_valid,
	output logic [DATA_W-1:0] q_out_data,
	input wire logic q_out_ready,
	output logic q_empty,
	output logic q_full,
	input wire logic [OPND_W-1:0] mul_a,
	input wire logic [OPND_W-1:0] mul_b,
	output logic [PROD_W-1:0] mul_product
);

	function automatic logic may_write(input mode_t m, input int p);
		if (p == 0)
			return m == MODE_SINGLE_PORT_RAM || m == MODE_SIMPLE_DUAL_RAM
				|| m == MODE_TRUE_DUAL_RAM;
		return m == MODE_TRUE_DUAL_RAM;
	endfunction

	function automatic logic may_read(input mode_t m, input int p);
		if (p == 0)
			return m == MODE_SINGLE_PORT_RAM || m == MODE_TRUE_DUAL_RAM
				|| m == MODE_SINGLE_PORT_ROM || m == MODE_DUAL_PORT_ROM
				|| m == MODE_MULTIPLIER;
		return m == MODE_SIMPLE_DUAL_RAM || m == MODE_TRUE_DUAL_RAM
			|| m == MODE_DUAL_PORT_ROM;
	endfunction

	// lane mask merge; an all-ones mask lets the strobe alone decide
	function automatic word_t merge_lanes(input word_t old_w, input word_t new_w,
		input logic [LANES-1:0] be);
		word_t res;
		res = old_w;
		for (int i = 0; i < LANES; i++)
		begin
			if (be[i])
				res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
		end
		return res;
	endfunction

	word_t mem [DEPTH];

	initial
	begin
		for (int i = 0; i < DEPTH; i++)
			mem[i] = rom_image(ADDR_W'(i));
	end

	logic port_en [2];
	port_req_t port_in [2];
	port_req_t req_q [2];
	word_t merged [2];
	word_t hold_q [2];
	word_t out_q [2];
	word_t rd_unreg [2];

	assign port_en[0] = ena_a;
	assign port_en[1] = ena_b;

	always_comb
	begin
		port_in[1] = port_b;
		port_in[0] = port_a;
		if (mode == MODE_MULTIPLIER)
		begin
			port_in[0] = REQ_IDLE;
			port_in[0].addr = {mul_a, mul_b};
			port_in[0].rd_en = 1'b1;
		end
	end

	for (genvar p = 0; p < 2; p++)
	begin : g_port
		word_t arr_rd;
		word_t rd_raw;

		// strobes act once per port enable; the address stays for the hold path
		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
				req_q[p] <= REQ_IDLE;
			else if (port_en[p])
			begin
				req_q[p] <= port_in[p];
				req_q[p].wr_en <= port_in[p].wr_en && may_write(mode, p);
				req_q[p].rd_en <= port_in[p].rd_en && may_read(mode, p);
			end
			else
			begin
				req_q[p].wr_en <= 1'b0;
				req_q[p].rd_en <= 1'b0;
			end
		end

		assign arr_rd = mem[req_q[p].addr];
		assign merged[p] = merge_lanes(arr_rd, req_q[p].wdata, req_q[p].byte_en);
		assign rd_raw = (req_q[p].wr_en && RDW_NEW_DATA) ? merged[p] : arr_rd;

		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
				hold_q[p] <= '0;
			else if (req_q[p].rd_en)
				hold_q[p] <= rd_raw;
		end

		assign rd_unreg[p] = req_q[p].rd_en ? rd_raw : hold_q[p];

		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
				out_q[p] <= '0;
			else
				out_q[p] <= rd_unreg[p];
		end
	end

	assign rd_data_a = OUT_REGISTERED ? out_q[0] : rd_unreg[0];
	assign rd_data_b = OUT_REGISTERED ? out_q[1] : rd_unreg[1];
	assign mul_product = rd_data_a[PROD_W-1:0];

	// shift register stored in the array as a circular buffer
	logic shift_q;
	logic [SHIFT_W-1:0] shift_in_q;
	logic [SHIFT_IDX_W-1:0] shift_ptr_q;
	logic is_shift;

	assign is_shift = mode == MODE_SHIFT_REGISTER;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shift_q <= 1'b0;
			shift_in_q <= '0;
		end
		else
		begin
			shift_q <= shift_en && is_shift;
			shift_in_q <= shift_in;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			shift_ptr_q <= '0;
		else if (shift_q)
			shift_ptr_q <= shift_ptr_q + 1'b1;
	end

	for (genvar t = 0; t < TAP_COUNT; t++)
	begin : g_tap
		logic [SHIFT_IDX_W-1:0] tap_idx;
		word_t tap_word;

		// word written spacing*(t+1) shifts ago; last tap is the oldest slot
		assign tap_idx = shift_ptr_q - SHIFT_IDX_W'((t + 1) * TAP_SPACING);
		assign tap_word = mem[ADDR_W'(tap_idx)];

		always_ff @(posedge clock or negedge reset_n)
		begin
			if (!reset_n)
				taps[t] <= '0;
			else if (shift_q)
				taps[t] <= tap_word[SHIFT_W-1:0];
		end
	end

	assign shift_out = taps[TAP_COUNT-1];

	// queue over the same array, with a two-entry buffer on the read side
	logic is_queue;
	logic pop_rate;
	logic push_q;
	word_t push_data_q;
	logic [ADDR_W-1:0] wr_ptr_q;
	logic [ADDR_W-1:0] rd_ptr_q;
	logic [QCNT_W-1:0] q_count_q;
	logic pop_go;
	word_t buf_q [BUF_DEPTH];
	logic buf_wr_q;
	logic buf_rd_q;
	logic [BUF_CNT_W-1:0] buf_count_q;
	logic buf_drain;

	assign is_queue = mode == MODE_SINGLE_CLOCK_QUEUE || mode == MODE_DUAL_CLOCK_QUEUE;
	// both sides share the one clock; the read side of the dual mode runs on ena_b
	assign pop_rate = (mode == MODE_DUAL_CLOCK_QUEUE) ? ena_b : ena_a;
	// counts the word still in the input register so the array cannot overrun
	assign q_in_ready = is_queue && ena_a
		&& (q_count_q + QCNT_W'(push_q)) < QUEUE_DEPTH;
	assign q_full = is_queue && q_count_q == QUEUE_DEPTH;
	assign q_empty = q_count_q == '0;
	// a word still in the push register is not yet visible, so empty blocks the pop
	assign pop_go = is_queue && pop_rate && !q_empty
		&& (buf_count_q != BUF_FULL || q_out_ready);
	assign q_out_valid = buf_count_q != '0;
	assign q_out_data = buf_q[buf_rd_q];
	assign buf_drain = q_out_valid && q_out_ready;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			push_q <= 1'b0;
			push_data_q <= '0;
		end
		else
		begin
			push_q <= q_push && q_in_ready;
			push_data_q <= q_push_data;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			q_count_q <= '0;
		end
		else
		begin
			if (push_q)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop_go)
				rd_ptr_q <= rd_ptr_q + 1'b1;
			q_count_q <= q_count_q + QCNT_W'(push_q) - QCNT_W'(pop_go);
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			buf_wr_q <= 1'b0;
			buf_rd_q <= 1'b0;
			buf_count_q <= '0;
		end
		else
		begin
			if (pop_go)
				buf_wr_q <= ~buf_wr_q;
			if (buf_drain)
				buf_rd_q <= ~buf_rd_q;
			buf_count_q <= buf_count_q + BUF_CNT_W'(pop_go) - BUF_CNT_W'(buf_drain);
		end
	end

	always_ff @(posedge clock)
	begin
		if (pop_go)
			buf_q[buf_wr_q] <= mem[rd_ptr_q];
	end

	// all array writes; port A lands last, so it wins a same-address collision
	always_ff @(posedge clock)
	begin
		for (int p = 1; p >= 0; p--)
		begin
			if (req_q[p].wr_en)
				mem[req_q[p].addr] <= merged[p];
		end
		if (shift_q)
			mem[ADDR_W'(shift_ptr_q)] <= DATA_W'(shift_in_q);
		if (push_q)
			mem[wr_ptr_q] <= push_data_q;
	end

endmodule // embedded_ram_block
`default_nettype wire

// ==== verif/embedded_ram_block_asserts.sv ====
// port-level checks for the embedded memory block
`default_nettype none
module ebr_checker
	import ebr_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire mode_t mode,
	input wire logic ena_a,
	input wire logic ena_b,
	input wire port_req_t port_a,
	input wire port_req_t port_b,
	input wire logic [DATA_W-1:0] rd_data_a,
	input wire logic [DATA_W-1:0] rd_data_b,
	input wire logic shift_en,
	input wire logic [TAP_COUNT-1:0][SHIFT_W-1:0] taps,
	input wire logic [SHIFT_W-1:0] shift_out,
	input wire logic q_out_valid,
	input wire logic [DATA_W-1:0] q_out_data,
	input wire logic q_out_ready,
	input wire logic [OPND_W-1:0] mul_a,
	input wire logic [OPND_W-1:0] mul_b,
	input wire logic [PROD_W-1:0] mul_product
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// consecutive shift edges; the chain check needs a full spacing of history
	localparam logic [7:0] RUN_NEED = 8'(TAP_SPACING + 2);
	logic [7:0] shift_run_q;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			shift_run_q <= 8'h00;
		else if (mode == MODE_SHIFT_REGISTER && shift_en && shift_run_q != 8'hFF)
			shift_run_q <= shift_run_q + 8'h01;
		else if (!(mode == MODE_SHIFT_REGISTER && shift_en))
			shift_run_q <= 8'h00;
	end
	hold_out_a:
		assert property (mode == MODE_SINGLE_PORT_RAM && !(ena_a && port_a.rd_en)
			|=> $stable(rd_data_a)) else $error("port a output moved without read");
	rom_first_a:
		assert property ((mode == MODE_SINGLE_PORT_ROM || mode == MODE_DUAL_PORT_ROM)
			&& ena_a && port_a.rd_en |=> rd_data_a[DATA_W-1:PROD_W] == IMAGE_TAG
			&& rd_data_a[PROD_W-1:0] == $past(port_a.addr[ADDR_W-1:OPND_W])
			* $past(port_a.addr[OPND_W-1:0]))
			else $error("port a image word wrong");
	rom_second_a:
		assert property (mode == MODE_DUAL_PORT_ROM && ena_b && port_b.rd_en
			|=> rd_data_b[DATA_W-1:PROD_W] == IMAGE_TAG
			&& rd_data_b[PROD_W-1:0] == $past(port_b.addr[ADDR_W-1:OPND_W])
			* $past(port_b.addr[OPND_W-1:0]))
			else $error("port b image word wrong");
	rom_hold_a:
		assert property (mode == MODE_DUAL_PORT_ROM && !(ena_b && port_b.rd_en)
			|=> $stable(rd_data_b)) else $error("port b output moved without read");
	mul_lookup_a:
		assert property (mode == MODE_MULTIPLIER && ena_a
			|=> mul_product == $past(mul_a) * $past(mul_b)) else $error("product wrong");
	chain_tap_a:
		assert property (shift_run_q >= RUN_NEED
			|-> shift_out == $past(taps[TAP_COUNT-2], TAP_SPACING))
			else $error("chain output does not continue the previous tap");
	tap_hold_a:
		assert property (mode == MODE_SHIFT_REGISTER && !shift_en |=> ##1 $stable(taps))
			else $error("taps moved without shift");
	stall_hold_a:
		assert property (q_out_valid && !q_out_ready |=> q_out_valid && $stable(q_out_data))
			else $error("queue output dropped during stall");
endmodule // ebr_checker
bind embedded_ram_block ebr_checker i_ebr_checker (.clock(clock), .reset_n(reset_n),
	.mode(mode), .ena_a(ena_a), .ena_b(ena_b), .port_a(port_a), .port_b(port_b),
	.rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .shift_en(shift_en), .taps(taps),
	.shift_out(shift_out), .q_out_valid(q_out_valid), .q_out_data(q_out_data),
	.q_out_ready(q_out_ready), .mul_a(mul_a), .mul_b(mul_b), .mul_product(mul_product));
`default_nettype wire

// ==== verif/fabric_sink.sv ====
// fabric-side consumer of the queue output with a stall pattern
`default_nettype none
module fabric_sink
	import ebr_pkg::*;
(
	input wire logic clock,
	input wire logic hold,
	input wire logic q_out_valid,
	input wire logic [DATA_W-1:0] q_out_data,
	output logic q_out_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	word_t got[$];
	int phase = 0;
	initial q_out_ready = 1'b0;
	// takes only against valid, so it never pops an empty queue
	always @(posedge clock)
	begin
		if (q_out_valid === 1'b1 && q_out_ready)
			got.push_back(q_out_data);
		phase++;
		#2;
		q_out_ready = !hold && (phase % 4 != 0);
	end
endmodule // fabric_sink
`default_nettype wire

// ==== verif/embedded_ram_block_bench.sv ====
// self-checking bench for the embedded memory block
`default_nettype none
module embedded_ram_block_bench;
	import ebr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	mode_t mode = MODE_MULTIPLIER;
	logic ena_a = 1'b1;
	logic ena_b = 1'b1;
	port_req_t port_a = REQ_IDLE;
	port_req_t port_b = REQ_IDLE;
	logic [SHIFT_W-1:0] shift_in = 8'h00;
	logic shift_en = 1'b0;
	logic q_push = 1'b0;
	word_t q_push_data = 32'h00000000;
	logic [OPND_W-1:0] mul_a = 4'h0;
	logic [OPND_W-1:0] mul_b = 4'h0;
	logic hold = 1'b1;
	word_t rd_data_a, rd_data_b, q_out_data;
	logic [TAP_COUNT-1:0][SHIFT_W-1:0] taps;
	logic [SHIFT_W-1:0] shift_out;
	logic [PROD_W-1:0] mul_product;
	logic q_in_ready, q_out_valid, q_out_ready, q_empty, q_full;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	always #25 clock = ~clock;
	embedded_ram_block i_embedded_ram_block (.clock(clock), .reset_n(reset_n), .mode(mode),
		.ena_a(ena_a), .ena_b(ena_b), .port_a(port_a), .port_b(port_b), .rd_data_a(rd_data_a),
		.rd_data_b(rd_data_b), .shift_in(shift_in), .shift_en(shift_en), .taps(taps),
		.shift_out(shift_out), .q_push(q_push), .q_push_data(q_push_data),
		.q_in_ready(q_in_ready), .q_out_valid(q_out_valid), .q_out_data(q_out_data),
		.q_out_ready(q_out_ready), .q_empty(q_empty), .q_full(q_full), .mul_a(mul_a),
		.mul_b(mul_b), .mul_product(mul_product));
	fabric_sink i_fabric_sink (.clock(clock), .hold(hold), .q_out_valid(q_out_valid),
		.q_out_data(q_out_data), .q_out_ready(q_out_ready));
	task automatic step();
		@(posedge clock);
		#2;
	endtask
	task automatic chk(input word_t got, input word_t exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// mode is static, so every scenario starts from a reset
	task automatic restart(input mode_t m);
		reset_n = 1'b0;
		mode = m;
		step();
		reset_n = 1'b1;
	endtask
	task automatic test_mul();
		restart(MODE_MULTIPLIER);
		for (int k = 0; k < 256; k++)
		begin
			mul_a = OPND_W'(k / 16);
			mul_b = OPND_W'(k % 16);
			step();
			chk(word_t'(mul_product), word_t'((k / 16) * (k % 16)));
		end
		$display("multiplier done");
	endtask
	task automatic test_rom();
		restart(MODE_DUAL_PORT_ROM);
		port_a = {8'h37, 32'hFFFFFFFF, 4'hF, 1'b1, 1'b1};
		port_b = {8'hFF, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		port_b = REQ_IDLE;
		chk(rd_data_a, {IMAGE_TAG, 8'h15});
		chk(rd_data_b, {IMAGE_TAG, 8'hE1});
		port_a = {8'h37, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		port_a = REQ_IDLE;
		chk(rd_data_a, {IMAGE_TAG, 8'h15});
		$display("rom done");
	endtask
	task automatic test_dual();
		restart(MODE_TRUE_DUAL_RAM);
		port_a = {8'h23, 32'hAABBCCDD, 4'h5, 1'b1, 1'b0};
		port_b = {8'h24, 32'h11223344, 4'hF, 1'b1, 1'b0};
		step();
		port_a = {8'h24, 32'h00000000, 4'h0, 1'b0, 1'b1};
		port_b = {8'h23, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		chk(rd_data_a, 32'h11223344);
		chk(rd_data_b, {IMAGE_TAG[23:16], 8'hBB, 8'h00, 8'hDD});
		ena_b = 1'b0;
		port_a = {8'h23, 32'h00000000, 4'h0, 1'b0, 1'b1};
		port_b = {8'h24, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		chk(rd_data_a, {IMAGE_TAG[23:16], 8'hBB, 8'h00, 8'hDD});
		chk(rd_data_b, {IMAGE_TAG[23:16], 8'hBB, 8'h00, 8'hDD});
		ena_b = 1'b1;
		restart(MODE_SIMPLE_DUAL_RAM);
		port_a = {8'h40, 32'h0BADF00D, 4'hF, 1'b1, 1'b0};
		port_b = {8'h23, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		port_a = REQ_IDLE;
		chk(rd_data_b, {IMAGE_TAG[23:16], 8'hBB, 8'h00, 8'hDD});
		port_b = {8'h40, 32'h00000000, 4'h0, 1'b0, 1'b1};
		step();
		port_b = REQ_IDLE;
		chk(rd_data_b, 32'h0BADF00D);
		$display("dual port done");
	endtask
	task automatic test_single();
		restart(MODE_SINGLE_PORT_RAM);
		port_a = {8'h05, 32'h12345678, 4'hF, 1'b1, 1'b1};
		step();
		chk(rd_data_a, 32'h12345678);
		port_a = {8'h06, 32'h9ABCDEF0, 4'hF, 1'b1, 1'b0};
		step();
		port_a = {8'h06, 32'h00000000, 4'h0, 1'b0, 1'b1};
		chk(rd_data_a, 32'h12345678);
		step();
		port_a = REQ_IDLE;
		chk(rd_data_a, 32'h9ABCDEF0);
		$display("single port done");
	endtask
	task automatic test_queue(input mode_t m);
		int n;
		logic taken;
		restart(m);
		hold = 1'b1;
		i_fabric_sink.got.delete();
		n = 0;
		taken = 1'b1;
		q_push = 1'b1;
		for (int k = 0; k < 300 && taken; k++)
		begin
			q_push_data = 32'hC0DE0000 + n;
			taken = (q_in_ready === 1'b1);
			step();
			n += int'(taken);
		end
		q_push = 1'b0;
		chk(word_t'(q_full), 32'h00000001);
		chk(word_t'(n >= QUEUE_DEPTH), 32'h00000001);
		hold = 1'b0;
		// the dual-clock pop side runs at half rate
		for (int k = 0; k < 3000 && i_fabric_sink.got.size() < n; k++)
		begin
			ena_b = (m != MODE_DUAL_CLOCK_QUEUE) || (k % 2 == 1);
			step();
		end
		ena_b = 1'b1;
		step();
		hold = 1'b1;
		chk(word_t'(i_fabric_sink.got.size()), word_t'(n));
		foreach (i_fabric_sink.got[i])
			chk(i_fabric_sink.got[i], 32'hC0DE0000 + i);
		chk(word_t'(q_empty), 32'h00000001);
		$display("queue done");
	endtask
	task automatic test_shift();
		restart(MODE_SHIFT_REGISTER);
		shift_en = 1'b1;
		for (int k = 1; k <= 80; k++)
		begin
			shift_in = SHIFT_W'(k);
			step();
		end
		shift_en = 1'b0;
		step();
		step();
		for (int t = 0; t < TAP_COUNT; t++)
			chk(word_t'(taps[t]), word_t'(80 - 16 * (t + 1)));
		chk(word_t'(shift_out), word_t'(80 - TAP_COUNT * TAP_SPACING));
		$display("shift register done");
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (12) @(posedge clock);
		#2;
		reset_n = 1'b1;
		test_mul();
		test_rom();
		test_dual();
		test_single();
		test_queue(MODE_SINGLE_CLOCK_QUEUE);
		test_queue(MODE_DUAL_CLOCK_QUEUE);
		test_shift();
		tally_and_finish();
	end
endmodule // embedded_ram_block_bench
`default_nettype wire
